// ===== scc_block_config_regs.sv
// Switched-capacitor config register bank with Wishbone slave and switch decode
`timescale 1ns/1ps
`include "scc_block_config_map.svh"

// One type A block: control 3 decode
module scc_type_a (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Configuration
	input wire scc_pkg::scc_reg_t cfg,
	input wire logic phase_invert,
	input wire logic auto_zero,
	// External phases
	input wire logic ext_first_nonoverlap_clock,
	input wire logic ext_second_nonoverlap_clock,
	// Decoded enables
	output logic fb_int_sw,
	output logic fb_gnd_sw,
	output logic [3:0] ref_sel,
	output logic [3:0] b_input_sel,
	output logic [1:0] power_level,
	output logic block_on
);
	logic int_second_nonoverlap_clock;
	logic next_fb_int_sw;
	logic [3:0] next_ref_sel;
	scc_pkg::scc_ref_e ref_code;
	scc_pkg::scc_pwr_e pwr_code;

	assign int_second_nonoverlap_clock = phase_invert ? ext_first_nonoverlap_clock : ext_second_nonoverlap_clock;
	assign ref_code = scc_pkg::scc_ref_e'(cfg[`SCC_A_REF_HI:`SCC_A_REF_LO]);
	assign pwr_code = scc_pkg::scc_pwr_e'(cfg[`SCC_A_PWR_HI:`SCC_A_PWR_LO]);

	always_comb begin
		if (!cfg[`SCC_A_FSW1]) begin
			next_fb_int_sw = 1'b0;
		end else if (!auto_zero) begin
			next_fb_int_sw = 1'b1;
		end else begin
			next_fb_int_sw = int_second_nonoverlap_clock;
		end
	end

	always_comb begin
		case (ref_code)
			scc_pkg::SCC_REF_AGND: next_ref_sel = 4'h1;
			scc_pkg::SCC_REF_HIGH: next_ref_sel = 4'h2;
			scc_pkg::SCC_REF_LOW: next_ref_sel = 4'h4;
			scc_pkg::SCC_REF_CMP: next_ref_sel = 4'h8;
			default: next_ref_sel = 4'h1;
		endcase
	end

	// Feedback switches
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fb_int_sw <= 1'b0;
			fb_gnd_sw <= 1'b0;
		end else begin
			fb_int_sw <= next_fb_int_sw;
			fb_gnd_sw <= cfg[`SCC_A_FSW0];
		end
	end

	// Input and reference selection
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ref_sel <= 4'h1;
			b_input_sel <= 4'h1;
		end else begin
			ref_sel <= next_ref_sel;
			b_input_sel <= 4'h1 << cfg[`SCC_A_BMUX_HI:`SCC_A_BMUX_LO];
		end
	end

	// Bias level
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_level <= 2'h0;
			block_on <= 1'b0;
		end else begin
			power_level <= pwr_code;
			block_on <= (pwr_code != scc_pkg::SCC_PWR_OFF);
		end
	end
endmodule : scc_type_a

// One type B block: control 0 and 1 decode plus column bus gating
module scc_type_b #(
	parameter int GATE_DELAY = `SCC_COL_GATE_DELAY
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Configuration
	input wire scc_pkg::scc_reg_t cr0,
	input wire scc_pkg::scc_reg_t cr1,
	input wire logic column_bus_output_gate,
	// External phases
	input wire logic ext_first_nonoverlap_clock,
	input wire logic ext_second_nonoverlap_clock,
	// Internal phases
	output logic int_first_nonoverlap_clock,
	output logic int_second_nonoverlap_clock,
	// Capacitor sizes
	output logic [5:0] fcap_units,
	output logic [4:0] acap_units,
	output logic [4:0] bcap_units,
	// A branch switching
	output logic a_bottom_input_en,
	output logic a_bottom_ref_en,
	output logic [5:0] a_input_sel,
	// Column bus
	output logic column_bus_drive
);
	logic next_first_nonoverlap_clock;
	logic next_second_nonoverlap_clock;
	logic next_drive;
	logic [3:0] gate_cnt;
	logic [2:0] amux;

	assign amux = cr1[`SCC_B_AMUX_HI:`SCC_B_AMUX_LO];

	if (GATE_DELAY < 0 || GATE_DELAY > 14) begin : g_chk
		$error("GATE_DELAY must lie in 0..14");
	end

	always_comb begin
		if (cr0[`SCC_B_PHASE]) begin
			next_first_nonoverlap_clock = ext_second_nonoverlap_clock;
			next_second_nonoverlap_clock = ext_first_nonoverlap_clock;
		end else begin
			next_first_nonoverlap_clock = ext_first_nonoverlap_clock;
			next_second_nonoverlap_clock = ext_second_nonoverlap_clock;
		end
	end

	always_comb begin
		if (!column_bus_output_gate) begin
			next_drive = 1'b0;
		end else if (cr0[`SCC_B_PHASE]) begin
			next_drive = 1'b1;
		end else begin
			next_drive = next_second_nonoverlap_clock && (gate_cnt >= 4'(GATE_DELAY));
		end
	end

	// Counts cycles into internal phase two
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_cnt <= 4'h0;
		end else if (!next_second_nonoverlap_clock) begin
			gate_cnt <= 4'h0;
		end else if (gate_cnt != 4'hF) begin
			gate_cnt <= gate_cnt + 4'h1;
		end
	end

	// Internal phases and column bus
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			int_first_nonoverlap_clock <= 1'b0;
			int_second_nonoverlap_clock <= 1'b0;
			column_bus_drive <= 1'b0;
		end else begin
			int_first_nonoverlap_clock <= next_first_nonoverlap_clock;
			int_second_nonoverlap_clock <= next_second_nonoverlap_clock;
			column_bus_drive <= next_drive;
		end
	end

	// A capacitor bottom plate phasing
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			a_bottom_input_en <= 1'b0;
			a_bottom_ref_en <= 1'b0;
		end else if (cr0[`SCC_B_ASIGN]) begin
			a_bottom_input_en <= next_second_nonoverlap_clock;
			a_bottom_ref_en <= next_first_nonoverlap_clock;
		end else begin
			a_bottom_input_en <= next_first_nonoverlap_clock;
			a_bottom_ref_en <= next_second_nonoverlap_clock;
		end
	end

	// Capacitor sizes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fcap_units <= `SCC_FCAP_SMALL;
			acap_units <= 5'h00;
			bcap_units <= 5'h00;
		end else begin
			fcap_units <= cr0[`SCC_B_FCAP] ? `SCC_FCAP_LARGE : `SCC_FCAP_SMALL;
			acap_units <= cr0[`SCC_B_ACAP_HI:`SCC_B_ACAP_LO];
			bcap_units <= cr1[`SCC_B_BCAP_HI:`SCC_B_BCAP_LO];
		end
	end

	// A input selection; reserved codes close every source
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			a_input_sel <= 6'h01;
		end else if (amux > `SCC_AMUX_LAST) begin
			a_input_sel <= 6'h00;
		end else begin
			a_input_sel <= 6'h01 << amux;
		end
	end
endmodule : scc_type_b

// Top: register bank on classic Wishbone feeding four type A and four type B decoders
module scc_block_config_regs #(
	parameter int GATE_DELAY = `SCC_COL_GATE_DELAY
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Phase clocks and bits held in neighbouring registers
	input wire logic first_nonoverlap_clock,
	input wire logic second_nonoverlap_clock,
	input wire logic [3:0] sca_phase_invert,
	input wire logic [3:0] sca_auto_zero,
	input wire logic [3:0] scb_column_bus_output_gate,
	// Type A outputs, block order 10, 12, 21, 23
	output logic [3:0] sca_integrator_feedback_sw,
	output logic [3:0] sca_feedback_ground_sw,
	output logic [15:0] sca_ref_sel,
	output logic [15:0] sca_b_input_sel,
	output logic [7:0] sca_power_level,
	output logic [3:0] sca_block_on,
	// Type B outputs, block order 11, 13, 20, 22
	output logic [3:0] scb_int_first_nonoverlap_clock,
	output logic [3:0] scb_int_second_nonoverlap_clock,
	output logic [23:0] scb_fcap_units,
	output logic [19:0] scb_acap_units,
	output logic [19:0] scb_bcap_units,
	output logic [3:0] scb_a_bottom_input_en,
	output logic [3:0] scb_a_bottom_ref_en,
	output logic [23:0] scb_a_input_sel,
	output logic [3:0] scb_column_bus_drive
);
	scc_pkg::scc_reg_t a_cr3 [4];
	scc_pkg::scc_reg_t b_cr0 [4];
	scc_pkg::scc_reg_t b_cr1 [4];
	logic req;
	logic hit;
	logic [1:0] blk;
	logic [1:0] kind;
	scc_pkg::scc_reg_t rd_val;

	if (GATE_DELAY < 0 || GATE_DELAY > 14) begin : g_chk
		$error("GATE_DELAY must lie in 0..14");
	end

	assign req = wb_cyc_i && wb_stb_i;

	// Address decode: kind 0 type A cr3, 1 type B cr0, 2 type B cr1
	always_comb begin
		hit = 1'b1;
		blk = 2'h0;
		kind = 2'h0;
		case (wb_adr_i[9:2])
			`SCC_IDX_A10_CR3: begin blk = 2'h0; kind = 2'h0; end
			`SCC_IDX_A12_CR3: begin blk = 2'h1; kind = 2'h0; end
			`SCC_IDX_A21_CR3: begin blk = 2'h2; kind = 2'h0; end
			`SCC_IDX_A23_CR3: begin blk = 2'h3; kind = 2'h0; end
			`SCC_IDX_B11_CR0: begin blk = 2'h0; kind = 2'h1; end
			`SCC_IDX_B13_CR0: begin blk = 2'h1; kind = 2'h1; end
			`SCC_IDX_B20_CR0: begin blk = 2'h2; kind = 2'h1; end
			`SCC_IDX_B22_CR0: begin blk = 2'h3; kind = 2'h1; end
			`SCC_IDX_B11_CR1: begin blk = 2'h0; kind = 2'h2; end
			`SCC_IDX_B13_CR1: begin blk = 2'h1; kind = 2'h2; end
			`SCC_IDX_B20_CR1: begin blk = 2'h2; kind = 2'h2; end
			`SCC_IDX_B22_CR1: begin blk = 2'h3; kind = 2'h2; end
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		case (kind)
			2'h0: rd_val = a_cr3[blk];
			2'h1: rd_val = b_cr0[blk];
			2'h2: rd_val = b_cr1[blk];
			default: rd_val = `SCC_REG_RESET;
		endcase
	end

	// Answer one cycle after the request, dropped the cycle after
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= req && hit && !wb_ack_o && !wb_err_o;
			wb_err_o <= req && !hit && !wb_ack_o && !wb_err_o;
		end
	end

	// Read data, zero on unmapped addresses
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_dat_o <= {24'h00_0000, hit ? rd_val : 8'h00};
		end
	end

	// Writes land on the edge that samples ack, byte lane 0 only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				a_cr3[i] <= `SCC_REG_RESET;
				b_cr0[i] <= `SCC_REG_RESET;
				b_cr1[i] <= `SCC_REG_RESET;
			end
		end else if (req && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
			case (kind)
				2'h0: a_cr3[blk] <= wb_dat_i[7:0];
				2'h1: b_cr0[blk] <= wb_dat_i[7:0];
				2'h2: b_cr1[blk] <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	for (genvar g = 0; g < 4; g++) begin : g_blk
		scc_type_a u_a (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.cfg(a_cr3[g]),
			.phase_invert(sca_phase_invert[g]),
			.auto_zero(sca_auto_zero[g]),
			.ext_first_nonoverlap_clock(first_nonoverlap_clock),
			.ext_second_nonoverlap_clock(second_nonoverlap_clock),
			.fb_int_sw(sca_integrator_feedback_sw[g]),
			.fb_gnd_sw(sca_feedback_ground_sw[g]),
			.ref_sel(sca_ref_sel[g*4 +: 4]),
			.b_input_sel(sca_b_input_sel[g*4 +: 4]),
			.power_level(sca_power_level[g*2 +: 2]),
			.block_on(sca_block_on[g])
		);

		scc_type_b #(
			.GATE_DELAY(GATE_DELAY)
		) u_b (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.cr0(b_cr0[g]),
			.cr1(b_cr1[g]),
			.column_bus_output_gate(scb_column_bus_output_gate[g]),
			.ext_first_nonoverlap_clock(first_nonoverlap_clock),
			.ext_second_nonoverlap_clock(second_nonoverlap_clock),
			.int_first_nonoverlap_clock(scb_int_first_nonoverlap_clock[g]),
			.int_second_nonoverlap_clock(scb_int_second_nonoverlap_clock[g]),
			.fcap_units(scb_fcap_units[g*6 +: 6]),
			.acap_units(scb_acap_units[g*5 +: 5]),
			.bcap_units(scb_bcap_units[g*5 +: 5]),
			.a_bottom_input_en(scb_a_bottom_input_en[g]),
			.a_bottom_ref_en(scb_a_bottom_ref_en[g]),
			.a_input_sel(scb_a_input_sel[g*6 +: 6]),
			.column_bus_drive(scb_column_bus_drive[g])
		);
	end
endmodule : scc_block_config_regs

// ===== scc_block_config_map.svh
// Offsets, field positions, reset values and counts of the switched-capacitor config bank
// Behaviour
// - Integrator feedback switch stays open whenever its control bit is cleared.
// - Bit set: switch closed always without auto-zero, else only during internal phase two.
// - Feedback ground switch enable follows its own bit; cleared bit keeps it open.
// - Reference select: 00 ground, 01 high, 10 low, 11 comparator-driven reference.
// - Type A bits 3..2 pick the B branch input from a per-block source set.
// - Power field bits 1..0: zero is off, higher codes raise bias current.
// - After reset every register is zero, so every type A block starts switched off.
// - Type B feedback capacitor bit gives 16 units cleared, 32 units set.
// - Type B bit 5 chooses which internal phase samples input and which reference.
// - A branch capacitor field is plain binary, code n gives n units.
// - Type B A-input codes 000..101 map to sources; 110 and 111 select nothing.
// - B branch capacitor field bits 4..0 is plain binary, zero to thirty-one units.
// - Clock inversion also changes how the column bus is driven, with the gate bit.
// - Gate clear floats the bus; set drives late phase two, or continuously if inverted.
`ifndef SCC_BLOCK_CONFIG_MAP_SVH
`define SCC_BLOCK_CONFIG_MAP_SVH

// Register indices; byte address is four times the index
`define SCC_IDX_A10_CR3 8'h83
`define SCC_IDX_B11_CR0 8'h84
`define SCC_IDX_B11_CR1 8'h85
`define SCC_IDX_A12_CR3 8'h8B
`define SCC_IDX_B13_CR0 8'h8C
`define SCC_IDX_B13_CR1 8'h8D
`define SCC_IDX_B20_CR0 8'h90
`define SCC_IDX_B20_CR1 8'h91
`define SCC_IDX_A21_CR3 8'h97
`define SCC_IDX_B22_CR0 8'h98
`define SCC_IDX_B22_CR1 8'h99
`define SCC_IDX_A23_CR3 8'h9F

`define SCC_REG_RESET 8'h00

// Type A control 3 fields
`define SCC_A_REF_HI 7
`define SCC_A_REF_LO 6
`define SCC_A_FSW1 5
`define SCC_A_FSW0 4
`define SCC_A_BMUX_HI 3
`define SCC_A_BMUX_LO 2
`define SCC_A_PWR_HI 1
`define SCC_A_PWR_LO 0

// Type B control 0 fields
`define SCC_B_FCAP 7
`define SCC_B_PHASE 6
`define SCC_B_ASIGN 5
`define SCC_B_ACAP_HI 4
`define SCC_B_ACAP_LO 0

// Type B control 1 fields
`define SCC_B_AMUX_HI 7
`define SCC_B_AMUX_LO 5
`define SCC_B_BCAP_HI 4
`define SCC_B_BCAP_LO 0

// Feedback capacitor sizes in units
`define SCC_FCAP_SMALL 6'h10
`define SCC_FCAP_LARGE 6'h20

// A-input codes in use; above this the code is reserved
`define SCC_AMUX_LAST 3'h5

// Cycles of internal phase two before the column bus gate opens
`define SCC_COL_GATE_DELAY 4

`endif

// ===== scc_pkg.sv
// Types shared by the switched-capacitor config bank
package scc_pkg;

	typedef enum logic [1:0] {
		SCC_REF_AGND,
		SCC_REF_HIGH,
		SCC_REF_LOW,
		SCC_REF_CMP
	} scc_ref_e;

	typedef enum logic [1:0] {
		SCC_PWR_OFF,
		SCC_PWR_LOW,
		SCC_PWR_MED,
		SCC_PWR_HIGH
	} scc_pwr_e;

	typedef logic [7:0] scc_reg_t;

endpackage : scc_pkg

// ===== scc_block_config_regs_monitor.sv
// Checker for the switched-capacitor config bank
`timescale 1ns/1ps
`include "scc_block_config_map.svh"
module scc_block_config_regs_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// Phases and neighbour bits
	input wire logic first_nonoverlap_clock,
	input wire logic second_nonoverlap_clock,
	input wire logic [3:0] sca_auto_zero,
	input wire logic [3:0] scb_column_bus_output_gate,
	// Decoded outputs
	input wire logic [3:0] sca_integrator_feedback_sw,
	input wire logic [3:0] sca_feedback_ground_sw,
	input wire logic [15:0] sca_ref_sel,
	input wire logic [7:0] sca_power_level,
	input wire logic [3:0] sca_block_on,
	input wire logic [3:0] scb_int_first_nonoverlap_clock,
	input wire logic [23:0] scb_fcap_units,
	input wire logic [23:0] scb_a_input_sel,
	input wire logic [3:0] scb_column_bus_drive
);
	logic [7:0] a10;
	logic [7:0] b0;
	logic [7:0] b1;
	logic wr;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Shadow of the watched registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			a10 <= 8'h00;
			b0 <= 8'h00;
			b1 <= 8'h00;
		end else if (wr) begin
			if (wb_adr_i[9:2] == `SCC_IDX_A10_CR3) a10 <= wb_dat_i[7:0];
			if (wb_adr_i[9:2] == `SCC_IDX_B11_CR0) b0 <= wb_dat_i[7:0];
			if (wb_adr_i[9:2] == `SCC_IDX_B11_CR1) b1 <= wb_dat_i[7:0];
		end
	end
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_answer;
		##1 (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	a_bus_answer: assert property (s_take |-> s_answer)
		else $error("bus request not answered by a one-cycle pulse");
	a_read_back: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == `SCC_IDX_A10_CR3
		|-> wb_dat_o == {24'h000000, a10}) else $error("read data differs from written value");
	a_fsw_open: assert property (!$past(a10[5]) |-> !sca_integrator_feedback_sw[0])
		else $error("feedback switch closed while disabled");
	a_fsw_closed: assert property ($past(a10[5]) && !$past(sca_auto_zero[0])
		|-> sca_integrator_feedback_sw[0]) else $error("feedback switch open without auto-zero");
	a_gnd_follow: assert property (sca_feedback_ground_sw[0] == $past(a10[4]))
		else $error("ground switch differs from its bit");
	a_ref_onehot: assert property (sca_ref_sel[3:0] == (4'h1 << $past(a10[7:6])))
		else $error("reference select wrong");
	a_power_map: assert property (sca_power_level[1:0] == $past(a10[1:0])
		&& sca_block_on[0] == (|$past(a10[1:0]))) else $error("power level wrong");
	a_fcap_size: assert property (scb_fcap_units[5:0] ==
		($past(b0[7]) ? `SCC_FCAP_LARGE : `SCC_FCAP_SMALL)) else $error("feedback cap wrong");
	a_amux_decode: assert property (scb_a_input_sel[5:0] == (($past(b1[7:5]) > `SCC_AMUX_LAST)
		? 6'h00 : (6'h01 << $past(b1[7:5])))) else $error("A input select wrong");
	a_phase_swap: assert property ($past(rst_n) |-> scb_int_first_nonoverlap_clock[0] == ($past(b0[6])
		? $past(second_nonoverlap_clock) : $past(first_nonoverlap_clock)))
		else $error("internal phase one wrong");
	a_bus_float: assert property (!$past(scb_column_bus_output_gate[0])
		|-> !scb_column_bus_drive[0]) else $error("column bus driven with gate clear");
endmodule : scc_block_config_regs_monitor

bind scc_block_config_regs scc_block_config_regs_monitor scc_block_config_regs_monitor_inst (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o),
	.first_nonoverlap_clock(first_nonoverlap_clock),
	.second_nonoverlap_clock(second_nonoverlap_clock),
	.sca_auto_zero(sca_auto_zero),
	.scb_column_bus_output_gate(scb_column_bus_output_gate),
	.sca_integrator_feedback_sw(sca_integrator_feedback_sw),
	.sca_feedback_ground_sw(sca_feedback_ground_sw),
	.sca_ref_sel(sca_ref_sel),
	.sca_power_level(sca_power_level),
	.sca_block_on(sca_block_on),
	.scb_int_first_nonoverlap_clock(scb_int_first_nonoverlap_clock),
	.scb_fcap_units(scb_fcap_units),
	.scb_a_input_sel(scb_a_input_sel),
	.scb_column_bus_drive(scb_column_bus_drive)
);

// ===== scc_block_config_regs_tb_top.sv
// Testbench for the switched-capacitor config bank
`timescale 1ns/1ps
`include "scc_block_config_map.svh"
module scc_block_config_regs_tb_top;
	logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic first_nonoverlap_clock, second_nonoverlap_clock, e;
	logic [3:0] sca_phase_invert, sca_auto_zero, scb_column_bus_output_gate;
	logic [3:0] sca_integrator_feedback_sw, sca_feedback_ground_sw, sca_block_on;
	logic [15:0] sca_ref_sel, sca_b_input_sel;
	logic [7:0] sca_power_level, v;
	logic [3:0] scb_int_first_nonoverlap_clock, scb_int_second_nonoverlap_clock, scb_a_bottom_input_en, scb_a_bottom_ref_en;
	logic [3:0] scb_column_bus_drive;
	logic [23:0] scb_fcap_units, scb_a_input_sel;
	logic [19:0] scb_acap_units, scb_bcap_units;
	int err_count, cmp_count;
	localparam logic [7:0] IDX [12] = '{`SCC_IDX_A10_CR3, `SCC_IDX_B11_CR0, `SCC_IDX_B11_CR1,
		`SCC_IDX_A12_CR3, `SCC_IDX_B13_CR0, `SCC_IDX_B13_CR1, `SCC_IDX_B20_CR0,
		`SCC_IDX_B20_CR1, `SCC_IDX_A21_CR3, `SCC_IDX_B22_CR0, `SCC_IDX_B22_CR1, `SCC_IDX_A23_CR3};

	scc_block_config_regs #(.GATE_DELAY(2)) scc_block_config_regs_inst (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.first_nonoverlap_clock(first_nonoverlap_clock),
		.second_nonoverlap_clock(second_nonoverlap_clock),
		.sca_phase_invert(sca_phase_invert), .sca_auto_zero(sca_auto_zero),
		.scb_column_bus_output_gate(scb_column_bus_output_gate),
		.sca_integrator_feedback_sw(sca_integrator_feedback_sw),
		.sca_feedback_ground_sw(sca_feedback_ground_sw),
		.sca_ref_sel(sca_ref_sel), .sca_b_input_sel(sca_b_input_sel),
		.sca_power_level(sca_power_level), .sca_block_on(sca_block_on),
		.scb_int_first_nonoverlap_clock(scb_int_first_nonoverlap_clock), .scb_int_second_nonoverlap_clock(scb_int_second_nonoverlap_clock),
		.scb_fcap_units(scb_fcap_units), .scb_acap_units(scb_acap_units),
		.scb_bcap_units(scb_bcap_units),
		.scb_a_bottom_input_en(scb_a_bottom_input_en),
		.scb_a_bottom_ref_en(scb_a_bottom_ref_en),
		.scb_a_input_sel(scb_a_input_sel),
		.scb_column_bus_drive(scb_column_bus_drive)
	);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict

	// One classic Wishbone cycle; waits for ack or err
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= {3'b000, s0};
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 40);
		if (n >= 40) begin
			err_count++;
			$display("CHECK FAILED %0t: bus timeout", $time);
			give_verdict();
		end
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : xfer

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wt

	task automatic ph(input logic a, input logic b, input int n);
		@(posedge sys_clk);
		first_nonoverlap_clock <= a;
		second_nonoverlap_clock <= b;
		wt(n);
	endtask : ph

	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, first_nonoverlap_clock, second_nonoverlap_clock} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, sca_phase_invert, sca_auto_zero} = '0;
		scb_column_bus_output_gate = 4'h0;
		wt(16);
		rst_n <= 1'b1;
		wt(1);
		chk(sca_block_on, 32'h0);
		chk(sca_ref_sel, 32'h1111);
		chk(scb_fcap_units, 32'h410410);
		chk(scb_a_input_sel, 32'h041041);
		for (int i = 0; i < 12; i++) begin
			xfer(1'b0, IDX[i], 8'h00, 1'b1);
			chk(q, 32'h0);
			xfer(1'b1, IDX[i], {4'(i), 4'h6}, 1'b1);
		end
		xfer(1'b1, IDX[0], 8'hFF, 1'b0);
		for (int i = 0; i < 12; i++) begin
			xfer(1'b0, IDX[i], 8'h00, 1'b1);
			chk(q, {24'h0, 4'(i), 4'h6});
		end
		wt(2);
		chk(sca_power_level, 32'hAA);
		chk(scb_bcap_units, {12'h0, 5'h06, 5'h16, 5'h16, 5'h06});
		xfer(1'b1, 8'h86, 8'hFF, 1'b1);
		chk(e, 1'b1);
		xfer(1'b0, 8'h86, 8'h00, 1'b1);
		chk(e, 1'b1);
		chk(q, 32'h0);
		for (int i = 0; i < 256; i++) begin
			v = 8'(i);
			xfer(1'b1, `SCC_IDX_A10_CR3, v, 1'b1);
			xfer(1'b1, `SCC_IDX_B11_CR0, v, 1'b1);
			xfer(1'b1, `SCC_IDX_B11_CR1, v, 1'b1);
			wt(2);
			chk(sca_ref_sel[3:0], 4'h1 << v[7:6]);
			chk(sca_integrator_feedback_sw[0], v[5]);
			chk(sca_feedback_ground_sw[0], v[4]);
			chk(sca_b_input_sel[3:0], 4'h1 << v[3:2]);
			chk({sca_block_on[0], sca_power_level[1:0]}, {|v[1:0], v[1:0]});
			chk(scb_fcap_units[5:0], v[7] ? 6'h20 : 6'h10);
			chk(scb_acap_units[4:0], v[4:0]);
			chk(scb_bcap_units[4:0], v[4:0]);
			chk(scb_a_input_sel[5:0], v[7:5] > 3'h5 ? 6'h00 : 6'h01 << v[7:5]);
		end
		xfer(1'b1, `SCC_IDX_A10_CR3, 8'h20, 1'b1);
		@(posedge sys_clk);
		sca_auto_zero <= 4'h1;
		ph(1'b0, 1'b1, 3);
		chk(sca_integrator_feedback_sw[0], 1'b1);
		ph(1'b1, 1'b0, 3);
		chk(sca_integrator_feedback_sw[0], 1'b0);
		sca_phase_invert <= 4'h1;
		wt(3);
		chk(sca_integrator_feedback_sw[0], 1'b1);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, `SCC_IDX_B11_CR0, {1'b0, 2'(k), 5'h00}, 1'b1);
			ph(1'b1, 1'b0, 3);
			chk({scb_int_second_nonoverlap_clock[0], scb_int_first_nonoverlap_clock[0]}, k[1] ? 2'b10 : 2'b01);
			chk(scb_a_bottom_input_en[0], (k[1] == k[0]));
			chk(scb_a_bottom_ref_en[0], k[1] ^ k[0]);
		end
		xfer(1'b1, `SCC_IDX_B11_CR0, 8'h00, 1'b1);
		@(posedge sys_clk);
		scb_column_bus_output_gate <= 4'h1;
		ph(1'b0, 1'b1, 1);
		chk(scb_column_bus_drive[0], 1'b0);
		wt(6);
		chk(scb_column_bus_drive[0], 1'b1);
		ph(1'b1, 1'b0, 3);
		chk(scb_column_bus_drive[0], 1'b0);
		xfer(1'b1, `SCC_IDX_B11_CR0, 8'h40, 1'b1);
		wt(3);
		chk(scb_column_bus_drive[0], 1'b1);
		scb_column_bus_output_gate <= 4'h0;
		wt(2);
		chk(scb_column_bus_drive[0], 1'b0);
		rst_n <= 1'b0;
		wt(2);
		rst_n <= 1'b1;
		xfer(1'b0, `SCC_IDX_A10_CR3, 8'h00, 1'b1);
		chk(sca_block_on, 32'h0);
		chk(q, 32'h0);
		give_verdict();
	end
endmodule : scc_block_config_regs_tb_top
